// ---- hw/qlo_divider_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "qlo_consts.svh"

// Behaviour
// - after power-up the divide-by-four may sit in any of four quarter phases relative to other devices.
// - the in-phase and quadrature lo of one device are exactly a quarter turn apart, except while sync reset holds both low.
// - all channels run from the one shared divider, so they stay in phase without any reset.
// - the active-high sync reset is accepted at any moment, with no alignment to the lo clock.
// - while sync reset is held the divider is forced to one fixed known state.
// - after sync reset falls the divider restarts on the third rising lo clock edge, behind the two-flop synchroniser.
// - holding the divider in reset gives a non-mixing path for gain measurement.
// - a channel demodulates only while its enable bit, bit 4 of register cw_channel_control, is set.
// - codes 0010, 0100 and 0110 shift a channel by 45, 90 and 135 degrees against code 0000.
// - the 4-bit phase code picks one of 16 states in 22.5 degree steps, 0000 being no shift.
// - the quadrature lo comes from a divide-by-four of the lo clock, 50 percent duty, reclocked.
// - equal codes on all devices plus one shared reset pulse give fully coherent summed outputs.
module qlo_divider_sync (
  // quad-rate lo clock and power-on reset
  input  wire logic                        SYS_CLK_I,
  input  wire logic                        RST_B_I,
  // shared synchronising reset pin, active high
  input  wire logic                        SYNC_RESET_I,
  // control register port
  input  wire logic                        REG_WR_I,
  input  wire logic [7:0]                  REG_ADDR_I,
  input  wire qlo_pkg::cw_ctrl_type        REG_WDATA_I,
  input  wire logic [7:0]                  REG_CHAN_SEL_I,
  input  wire logic [2:0]                  REG_RD_CHAN_I,
  output var  qlo_pkg::cw_ctrl_type        REG_RDATA_O,
  // device lo
  output var  logic                        LO_I_O,
  output var  logic                        LO_Q_O,
  output var  logic                        NON_MIXING_O,
  // per-channel lo
  output var  qlo_pkg::ch_lo_type          CH_LO_O,
  output var  qlo_pkg::ch_phase_arr_type   CH_PHASE_O,
  output var  logic [7:0]                  CH_ACTIVE_O
);
  import qlo_pkg::*;

  logic              rst_meta;
  logic              rst_n;
  logic              sync_meta;
  logic              sync_hold;
  logic [1:0]        div_cnt_reg;
  logic [1:0]        div_cnt_next;
  cw_ctrl_type [7:0] ctrl_reg;
  logic              reg_hit;

  function automatic logic [3:0] phase_word(input logic [1:0] cnt, input logic [3:0] code);
    phase_word = 4'({cnt, 2'b00} + code);
  endfunction : phase_word

  // the upper half of the 16-step turn drives the square lo high
  function automatic logic lo_level(input logic [3:0] word);
    lo_level = word[3];
  endfunction : lo_level

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pin is asynchronous to the lo clock, two flops before use
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= 1'b0;
      sync_hold <= 1'b0;
    end else begin
      sync_meta <= SYNC_RESET_I;
      sync_hold <= sync_meta;
    end
  end

  assign div_cnt_next = sync_hold ? `QLO_DIV_RESET : 2'(div_cnt_reg + 2'h1);

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= `QLO_POWERUP_PHASE;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  assign reg_hit = (REG_ADDR_I == `QLO_REG_CW_CTRL);

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= {`QLO_NUM_CH{`QLO_CW_CTRL_RESET}};
    end else if (REG_WR_I && reg_hit) begin
      for (int k = 0; k < `QLO_NUM_CH; k++) begin
        if (REG_CHAN_SEL_I[k]) begin
          ctrl_reg[k] <= '{rsvd: 3'h0, enable: REG_WDATA_I.enable, phase: REG_WDATA_I.phase};
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA_O <= `QLO_CW_CTRL_RESET;
    end else begin
      REG_RDATA_O <= reg_hit ? ctrl_reg[REG_RD_CHAN_I] : `QLO_CW_CTRL_RESET;
    end
  end

  // device quadrature pair, reclocked from the divider state
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      LO_I_O       <= 1'b0;
      LO_Q_O       <= 1'b0;
      NON_MIXING_O <= 1'b0;
    end else begin
      LO_I_O       <= div_cnt_reg[1];
      LO_Q_O       <= div_cnt_reg[1] ^ div_cnt_reg[0];
      NON_MIXING_O <= sync_hold;
    end
  end

  // every channel taps the same divider state
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CH_LO_O     <= '0;
      CH_PHASE_O  <= '0;
      CH_ACTIVE_O <= '0;
    end else begin
      for (int k = 0; k < `QLO_NUM_CH; k++) begin
        CH_PHASE_O[k]  <= phase_word(div_cnt_reg, ctrl_reg[k].phase);
        CH_ACTIVE_O[k] <= ctrl_reg[k].enable && !sync_hold;
        CH_LO_O.i_lo[k] <= ctrl_reg[k].enable &&
                           lo_level(phase_word(div_cnt_reg, ctrl_reg[k].phase));
        CH_LO_O.q_lo[k] <= ctrl_reg[k].enable &&
                           lo_level(4'(phase_word(div_cnt_reg, ctrl_reg[k].phase)
                                       + `QLO_QUARTER_STEP));
      end
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_held_at_zero;
    div_cnt_reg == 2'h0;
  endsequence

  sequence s_first_step;
    div_cnt_reg == 2'h1;
  endsequence

  chk_reset_state: assert property (sync_hold |=> div_cnt_reg == 2'h0)
    else $error("divider not held at zero during sync reset");

  chk_restart_edge: assert property ($fell(sync_hold) |-> s_held_at_zero ##1 s_first_step)
    else $error("divider did not restart on the next edge");

  chk_div_step: assert property (!sync_hold |=> div_cnt_reg == 2'($past(div_cnt_reg) + 2'h1))
    else $error("divider did not advance by one");

  chk_iq_quadrature: assert property (!$past(sync_hold, 2) && !$past(sync_hold, 3)
                                      |-> LO_I_O == $past(LO_Q_O))
    else $error("i and q are not a quarter turn apart");

  chk_nonmix_flag: assert property (sync_hold ##1 sync_hold |=> NON_MIXING_O && !LO_I_O && !LO_Q_O)
    else $error("lo toggles while non-mixing");

  chk_reg_write: assert property (REG_WR_I && reg_hit && REG_CHAN_SEL_I[0]
                                  |=> ctrl_reg[0].phase == $past(REG_WDATA_I.phase))
    else $error("control write not stored");

  chk_rdata_read: assert property (reg_hit && REG_RD_CHAN_I == 3'h0
                                   |=> REG_RDATA_O == $past(ctrl_reg[0]))
    else $error("read data does not follow channel byte");

  chk_rdata_refuse: assert property (!reg_hit |=> REG_RDATA_O == `QLO_CW_CTRL_RESET)
    else $error("unmapped address returned data");

  chk_ch0_gate: assert property (!ctrl_reg[0].enable
                                 |=> !CH_LO_O.i_lo[0] && !CH_LO_O.q_lo[0] && !CH_ACTIVE_O[0])
    else $error("disabled channel zero still mixing");

  chk_active_hold: assert property (sync_hold |=> CH_ACTIVE_O == 8'h00)
    else $error("channel active while dividers held");

  chk_nonmix_clear: assert property (!sync_hold |=> !NON_MIXING_O)
    else $error("non-mixing flag without sync reset");

  // the sync pin reaches the hold flop two edges after it is sampled
  chk_sync_rise: assert property (SYNC_RESET_I |-> ##2 sync_hold)
    else $error("sync reset not taken");

  chk_sync_fall: assert property (!SYNC_RESET_I |-> ##2 !sync_hold)
    else $error("sync reset not released");

  chk_i_duty: assert property ($rose(LO_I_O) && !$past(sync_hold) |=> LO_I_O)
    else $error("in-phase lo high for one clock only");

  chk_q_duty: assert property ($rose(LO_Q_O) && !$past(sync_hold) |=> LO_Q_O)
    else $error("quadrature lo high for one clock only");

  for (genvar g = 1; g < `QLO_NUM_CH; g++) begin : g_chk
    chk_shared_lo: assert property (ctrl_reg[g].phase == ctrl_reg[0].phase
                                    |=> CH_PHASE_O[g] == CH_PHASE_O[0])
      else $error("equal codes give unequal phase");

    chk_enable_gate: assert property (!ctrl_reg[g].enable
                                      |=> !CH_LO_O.i_lo[g] && !CH_LO_O.q_lo[g] && !CH_ACTIVE_O[g])
      else $error("disabled channel still mixing");

    chk_enable_on: assert property (ctrl_reg[g].enable && !sync_hold |=> CH_ACTIVE_O[g])
      else $error("enabled channel not active");

    chk_phase_offset: assert property (1'b1 |=> 4'(CH_PHASE_O[g] - CH_PHASE_O[0])
                                       == 4'($past(ctrl_reg[g].phase) - $past(ctrl_reg[0].phase)))
      else $error("channel phase offset wrong");
  end

endmodule : qlo_divider_sync
`default_nettype wire

// ---- hw/qlo_consts.svh ----
`ifndef QLO_CONSTS_SVH
`define QLO_CONSTS_SVH

// register address of the per-channel cw control byte
`define QLO_REG_CW_CTRL     8'h2D
// field positions inside the control byte
`define QLO_FLD_EN_BIT      4
`define QLO_FLD_PHASE_LSB   0
`define QLO_FLD_PHASE_MSB   3
// reset values
`define QLO_CW_CTRL_RESET   8'h00
`define QLO_DIV_RESET       2'h0
// divider state after a power-on reset, one of the four quarter phases
`define QLO_POWERUP_PHASE   2'h0
// a quarter turn in 22.5 degree phase units
`define QLO_QUARTER_STEP    4'h4
// number of channels
`define QLO_NUM_CH          8

`endif

// ---- hw/qlo_pkg.sv ----
package qlo_pkg;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       enable;
    logic [3:0] phase;
  } cw_ctrl_type;

  typedef logic [7:0][3:0] ch_phase_arr_type;

  typedef struct packed {
    logic [7:0] i_lo;
    logic [7:0] q_lo;
  } ch_lo_type;

endpackage : qlo_pkg

// ---- test/qlo_sys_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module qlo_sys_ctrl (
  // lo clock from the bench
  input  wire logic clk_i,
  // shared sync reset pin
  output var  logic sync_reset_o
);
  initial sync_reset_o = 1'b0;
  // falling-edge moves give half a period of setup before the next rise
  task automatic raise();
    @(negedge clk_i) sync_reset_o = 1'b1;
  endtask : raise
  task automatic drop();
    @(negedge clk_i) sync_reset_o = 1'b0;
  endtask : drop
endmodule : qlo_sys_ctrl
`default_nettype wire

// ---- test/quadrature_lo_divider_sync_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module quadrature_lo_divider_sync_test;
  import qlo_pkg::*;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             sync_rst;
  logic             wr = 1'b0;
  logic [7:0]       addr = 8'h00;
  cw_ctrl_type      wdata = 8'h00;
  logic [7:0]       sel = 8'h00;
  logic [2:0]       rd_ch = 3'h0;
  cw_ctrl_type      rdata;
  logic             lo_i;
  logic             lo_q;
  logic             non_mix;
  ch_lo_type        ch_lo;
  ch_phase_arr_type ch_ph;
  logic [7:0]       ch_act;
  int               num_errors = 0;
  int               comparisons = 0;
  // lo levels per clock from the edge after the hold drops
  logic [7:0]       pat_i = 8'hCC;
  logic [7:0]       pat_q = 8'h66;

  always #50 clk = ~clk;

  qlo_sys_ctrl qlo_sys_ctrl_i (.clk_i(clk), .sync_reset_o(sync_rst));
  qlo_divider_sync qlo_divider_sync_i (
    .SYS_CLK_I(clk), .RST_B_I(rst_b), .SYNC_RESET_I(sync_rst),
    .REG_WR_I(wr), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_CHAN_SEL_I(sel), .REG_RD_CHAN_I(rd_ch), .REG_RDATA_O(rdata),
    .LO_I_O(lo_i), .LO_Q_O(lo_q), .NON_MIXING_O(non_mix),
    .CH_LO_O(ch_lo), .CH_PHASE_O(ch_ph), .CH_ACTIVE_O(ch_act));

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] s, input cw_ctrl_type d);
    @(posedge clk) #1;
    wr = 1'b1;
    addr = a;
    sel = s;
    wdata = d;
    @(posedge clk) #1;
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [2:0] c, input cw_ctrl_type e);
    @(posedge clk) #1;
    addr = a;
    rd_ch = c;
    @(posedge clk) #1;
    `CHK(rdata, e)
  endtask : rd_reg

  task automatic stop_test();
    $display("comparisons=%0d errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    #500000;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(8'h2D, 3'h0, 8'h00);
    wr_reg(8'h2D, 8'h01, 8'h14);
    rd_reg(8'h2D, 3'h0, 8'h14);
    `CHK(ch_act, 8'h01)
    wr_reg(8'h2C, 8'h01, 8'h03);
    rd_reg(8'h2D, 3'h0, 8'h14);
    rd_reg(8'h2C, 3'h0, 8'h00);
    $display("test registers done");
    // channel 0 stays at code 0 while channel 1 walks every code
    wr_reg(8'h2D, 8'h01, 8'h10);
    for (int c = 0; c < 16; c++) begin
      wr_reg(8'h2D, 8'h02, cw_ctrl_type'({4'h1, c[3:0]}));
      @(posedge clk) #1;
      `CHK(4'(ch_ph[1] - ch_ph[0]), c[3:0])
    end
    `CHK(ch_lo.i_lo[7:2] | ch_lo.q_lo[7:2], 6'h00)
    // reserved bits are dropped; channel 1 ends a quarter turn ahead
    wr_reg(8'h2D, 8'h02, 8'hF4);
    rd_reg(8'h2D, 3'h1, 8'h14);
    $display("test phase codes done");
    qlo_sys_ctrl_i.raise();
    repeat (4) @(posedge clk);
    #1;
    `CHK({non_mix, lo_i, lo_q, ch_act}, 11'h400)
    qlo_sys_ctrl_i.drop();
    repeat (2) @(posedge clk) #1;
    `CHK(non_mix, 1'b1)
    @(posedge clk) #1;
    `CHK(non_mix, 1'b0)
    for (int k = 0; k < 8; k++) begin
      `CHK({lo_i, lo_q}, {pat_i[k], pat_q[k]})
      `CHK(ch_lo.i_lo[1:0], {pat_i[3'(k + 1)], pat_i[k]})
      `CHK(ch_lo.q_lo[1:0], {pat_q[3'(k + 1)], pat_q[k]})
      @(posedge clk) #1;
    end
    $display("test sync reset done");
    stop_test();
  end
endmodule : quadrature_lo_divider_sync_test
`default_nettype wire
